//--- etsr_top.sv
`timescale 1ns/1ps
// What this block does
// R01 - Reads return the unit chosen by bit 8 of the unit index register.
// R02 - Each seconds register shows the 32-bit captured seconds, read-only.
// R03 - Nanoseconds bit 30 is one for a rising edge, zero for a falling one.
// R04 - Nanoseconds bits 29:0 hold the captured time; bit 31 reads zero.
// R05 - Phase bits 2:0 give the 8 ns sub-cycle of a 40 ns period; rest zero.
// R06 - Phase codes: 000 0ns, 001 8ns, 011 24ns, 100 32ns; 16ns taken as 010.
// R07 - Every slot field is read-only and resets to zero.
// R08 - Edge, nanoseconds, seconds and phase of a slot load from one event.
module etsr_top
    import etsr_pkg::*;
(
    input  wire logic                          mclk,
    input  wire logic                          reset_n,
    input  wire logic [31:0]                   unit_index,
    input  wire logic [NUM_UNITS*NUM_SLOTS-1:0] cap_stb,
    input  wire logic [NS_W-1:0]               cap_ns,
    input  wire logic [SEC_W-1:0]              cap_sec,
    input  wire logic [PHASE_W-1:0]            cap_phase,
    input  wire logic                          cap_rise,
    input  wire logic                          rd_en,
    input  wire logic [11:0]                   rd_addr,
    output logic      [31:0]                   rd_data,
    output logic                               rd_valid,
    output logic                               rd_hit
);

    localparam int NSL = NUM_UNITS * NUM_SLOTS;

    logic [NS_W-1:0]    s_ns    [NSL];
    logic [SEC_W-1:0]   s_sec   [NSL];
    logic [PHASE_W-1:0] s_phase [NSL];
    logic               s_rise  [NSL];

    logic [31:0]    rd_data_r,  rd_data_nxt;
    logic           rd_valid_r, rd_valid_nxt;
    logic           rd_hit_r,   rd_hit_nxt;
    etsr_rd_state_t st_r,       st_nxt;

    // ------------------------------------------------------------
    // Sample slots, one per unit and slot number
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NSL; g++) begin : g_slot
            etsr_slot u_slot (
                .mclk       (mclk),
                .reset_n    (reset_n),
                .cap_stb    (cap_stb[g]),
                .cap_ns     (cap_ns),
                .cap_sec    (cap_sec),
                .cap_phase  (cap_phase),
                .cap_rise   (cap_rise),
                .slot_ns    (s_ns[g]),
                .slot_sec   (s_sec[g]),
                .slot_phase (s_phase[g]),
                .slot_rise  (s_rise[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Read decode
    // ------------------------------------------------------------
    function automatic logic [31:0] ns_word(input int i);
        ns_word = {1'b0, s_rise[i], s_ns[i]}; // R03 R04
    endfunction

    function automatic logic [31:0] ph_word(input int i);
        ph_word = {29'h0000000, s_phase[i]}; // R05 R06
    endfunction

    always_comb begin
        int base;
        base         = 0;
        rd_data_nxt  = REG_RESET;
        rd_hit_nxt   = 1'b0;
        rd_valid_nxt = rd_en;
        st_nxt       = rd_en ? ETSR_HOLD : ETSR_IDLE;
        if (unit_index[UNIT_IDX_BIT]) begin // R01
            base = NUM_SLOTS;
        end
        if (rd_en) begin
            rd_hit_nxt = 1'b1;
            unique case (rd_addr)
                SAMPLE5_SECONDS_OFS: begin
                    rd_data_nxt = s_sec[base]; // R02
                end
                SAMPLE5_PHASE_OFS: begin
                    rd_data_nxt = ph_word(base);
                end
                SAMPLE6_NANOSECONDS_OFS: begin
                    rd_data_nxt = ns_word(base + 1);
                end
                SAMPLE6_SECONDS_OFS: begin
                    rd_data_nxt = s_sec[base + 1]; // R02
                end
                SAMPLE6_PHASE_OFS: begin
                    rd_data_nxt = ph_word(base + 1);
                end
                SAMPLE7_NANOSECONDS_OFS: begin
                    rd_data_nxt = ns_word(base + 2);
                end
                default: begin
                    rd_hit_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r  <= REG_RESET;
            rd_valid_r <= 1'b0;
            rd_hit_r   <= 1'b0;
            st_r       <= ETSR_IDLE;
        end else begin
            rd_data_r  <= rd_data_nxt;
            rd_valid_r <= rd_valid_nxt;
            rd_hit_r   <= rd_hit_nxt;
            st_r       <= st_nxt;
        end
    end

    assign rd_data  = rd_data_r;
    assign rd_valid = rd_valid_r;
    assign rd_hit   = rd_hit_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic unit_sel;

    assign unit_sel = unit_index[UNIT_IDX_BIT];

    sequence rd_ns6_seq;
        rd_en && rd_addr == SAMPLE6_NANOSECONDS_OFS;
    endsequence

    rd_latency_a: assert property ( // R01
        @(posedge mclk) disable iff (!reset_n)
        rd_en |=> rd_valid && st_r == ETSR_HOLD)
        else $error("read answer missing after one cycle");

    ns_reserved_a: assert property ( // R04
        @(posedge mclk) disable iff (!reset_n)
        rd_ns6_seq |=> rd_data[31] == 1'b0)
        else $error("nanoseconds bit 31 not zero");

    edge_flag_a: assert property ( // R03
        @(posedge mclk) disable iff (!reset_n)
        rd_ns6_seq |=> rd_data[EDGE_BIT] ==
            ($past(unit_sel) ? $past(s_rise[4]) : $past(s_rise[1])))
        else $error("edge flag not in bit 30");

    phase_res_a: assert property ( // R05
        @(posedge mclk) disable iff (!reset_n)
        rd_en && (rd_addr == SAMPLE5_PHASE_OFS ||
                  rd_addr == SAMPLE6_PHASE_OFS)
        |=> rd_data[31:PHASE_W] == 29'h0000000)
        else $error("phase reserved bits not zero");

    unit_sel_a: assert property ( // R01
        @(posedge mclk) disable iff (!reset_n)
        rd_en && rd_addr == SAMPLE5_SECONDS_OFS
        |=> rd_data ==
            ($past(unit_sel) ? $past(s_sec[3]) : $past(s_sec[0])))
        else $error("wrong unit seconds returned");

    sec6_a: assert property ( // R02
        @(posedge mclk) disable iff (!reset_n)
        rd_en && rd_addr == SAMPLE6_SECONDS_OFS
        |=> rd_data ==
            ($past(unit_sel) ? $past(s_sec[4]) : $past(s_sec[1])))
        else $error("sixth seconds mismatch");

    miss_zero_a: assert property ( // R07
        @(posedge mclk) disable iff (!reset_n)
        rd_en && !rd_hit_nxt |=> rd_valid && !rd_hit && rd_data == 32'h0)
        else $error("unmapped read not zero");

    sequence rd_ns7_seq;
        rd_en && rd_addr == SAMPLE7_NANOSECONDS_OFS;
    endsequence

    sequence rd_ph5_seq;
        rd_en && rd_addr == SAMPLE5_PHASE_OFS;
    endsequence

    sequence rd_ph6_seq;
        rd_en && rd_addr == SAMPLE6_PHASE_OFS;
    endsequence

    hit_s5_a: assert property ( // R02
        @(posedge mclk) disable iff (!reset_n)
        rd_en && rd_addr == SAMPLE5_SECONDS_OFS |=> rd_valid && rd_hit)
        else $error("fifth seconds read not mapped");

    ns6_value_a: assert property ( // R04
        @(posedge mclk) disable iff (!reset_n)
        rd_ns6_seq |=> rd_hit && rd_data[NS_W-1:0] ==
            ($past(unit_sel) ? $past(s_ns[4]) : $past(s_ns[1])))
        else $error("sixth nanoseconds mismatch");

    ns7_value_a: assert property ( // R04
        @(posedge mclk) disable iff (!reset_n)
        rd_ns7_seq |=> rd_hit && rd_data[31] == 1'b0 &&
            rd_data[NS_W-1:0] ==
            ($past(unit_sel) ? $past(s_ns[5]) : $past(s_ns[2])))
        else $error("seventh nanoseconds mismatch");

    edge7_flag_a: assert property ( // R03
        @(posedge mclk) disable iff (!reset_n)
        rd_ns7_seq |=> rd_data[EDGE_BIT] ==
            ($past(unit_sel) ? $past(s_rise[5]) : $past(s_rise[2])))
        else $error("seventh edge flag not in bit 30");

    phase5_code_a: assert property ( // R06
        @(posedge mclk) disable iff (!reset_n)
        rd_ph5_seq |=> rd_hit && rd_data[PHASE_W-1:0] ==
            ($past(unit_sel) ? $past(s_phase[3]) : $past(s_phase[0])))
        else $error("fifth phase code mismatch");

    phase6_code_a: assert property ( // R06
        @(posedge mclk) disable iff (!reset_n)
        rd_ph6_seq |=> rd_hit && rd_data[PHASE_W-1:0] ==
            ($past(unit_sel) ? $past(s_phase[4]) : $past(s_phase[1])))
        else $error("sixth phase code mismatch");

    idle_zero_a: assert property ( // R07
        @(posedge mclk) disable iff (!reset_n)
        !rd_en |=> !rd_valid && !rd_hit && rd_data == REG_RESET)
        else $error("read port not idle without request");

endmodule

//--- etsr_pkg.sv
package etsr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] SAMPLE5_SECONDS_OFS     = 12'h588;
    localparam logic [11:0] SAMPLE5_PHASE_OFS       = 12'h58C;
    localparam logic [11:0] SAMPLE6_NANOSECONDS_OFS = 12'h590;
    localparam logic [11:0] SAMPLE6_SECONDS_OFS     = 12'h594;
    localparam logic [11:0] SAMPLE6_PHASE_OFS       = 12'h598;
    localparam logic [11:0] SAMPLE7_NANOSECONDS_OFS = 12'h59C;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          NS_W          = 30;
    localparam int          EDGE_BIT      = 30;
    localparam int          SEC_W         = 32;
    localparam int          PHASE_W       = 3;
    localparam int          UNIT_IDX_BIT  = 8;
    localparam int          NUM_UNITS     = 2;
    localparam int          NUM_SLOTS     = 3;
    localparam int          FIRST_SLOT    = 5;
    localparam logic [31:0] REG_RESET     = 32'h0000_0000;

    // ------------------------------------------------------------
    // Phase codes: 8 ns sub-cycles of a 40 ns base period
    // ------------------------------------------------------------
    localparam logic [2:0]  PH_0NS        = 3'h0;
    localparam logic [2:0]  PH_8NS        = 3'h1;
    localparam logic [2:0]  PH_16NS       = 3'h2;
    localparam logic [2:0]  PH_24NS       = 3'h3;
    localparam logic [2:0]  PH_32NS       = 3'h4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          RD_LATENCY    = 1;

    typedef enum logic [0:0] {
        ETSR_IDLE = 1'b0,
        ETSR_HOLD = 1'b1
    } etsr_rd_state_t;

endpackage

//--- etsr_slot.sv
`timescale 1ns/1ps
module etsr_slot
    import etsr_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic               reset_n,
    input  wire logic               cap_stb,
    input  wire logic [NS_W-1:0]    cap_ns,
    input  wire logic [SEC_W-1:0]   cap_sec,
    input  wire logic [PHASE_W-1:0] cap_phase,
    input  wire logic               cap_rise,
    output logic      [NS_W-1:0]    slot_ns,
    output logic      [SEC_W-1:0]   slot_sec,
    output logic      [PHASE_W-1:0] slot_phase,
    output logic                    slot_rise
);

    logic [NS_W-1:0]    ns_r,    ns_nxt;
    logic [SEC_W-1:0]   sec_r,   sec_nxt;
    logic [PHASE_W-1:0] ph_r,    ph_nxt;
    logic               rise_r,  rise_nxt;

    // ------------------------------------------------------------
    // Capture all fields together
    // ------------------------------------------------------------
    always_comb begin
        ns_nxt   = ns_r;
        sec_nxt  = sec_r;
        ph_nxt   = ph_r;
        rise_nxt = rise_r;
        if (cap_stb) begin // R08
            ns_nxt   = cap_ns;
            sec_nxt  = cap_sec;
            ph_nxt   = cap_phase;
            rise_nxt = cap_rise;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin // R07
            ns_r   <= REG_RESET[NS_W-1:0];
            sec_r  <= REG_RESET[SEC_W-1:0];
            ph_r   <= REG_RESET[PHASE_W-1:0];
            rise_r <= 1'b0;
        end else begin
            ns_r   <= ns_nxt;
            sec_r  <= sec_nxt;
            ph_r   <= ph_nxt;
            rise_r <= rise_nxt;
        end
    end

    assign slot_ns    = ns_r;
    assign slot_sec   = sec_r;
    assign slot_phase = ph_r;
    assign slot_rise  = rise_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence cap_seq;
        cap_stb ##1 1'b1;
    endsequence

    slot_update_a: assert property ( // R08
        @(posedge mclk) disable iff (!reset_n)
        cap_seq |-> (ns_r == $past(cap_ns) && sec_r == $past(cap_sec)
                     && ph_r == $past(cap_phase)
                     && rise_r == $past(cap_rise)))
        else $error("slot fields not captured together");

    slot_hold_a: assert property ( // R07
        @(posedge mclk) disable iff (!reset_n)
        !cap_stb |=> $stable(sec_r) && $stable(ns_r) && $stable(ph_r)
                     && $stable(rise_r))
        else $error("slot changed without capture");

endmodule

//--- etsr_evt_src.sv
`timescale 1ns/1ps
// ----------------------------------------
// Event source feeding the capture inputs
// ----------------------------------------
module etsr_evt_src
    import etsr_pkg::*;
(
    input  wire logic               mclk,
    input  wire logic [5:0]         ev_mask,
    input  wire logic [NS_W-1:0]    ev_ns,
    input  wire logic [SEC_W-1:0]   ev_sec,
    input  wire logic [PHASE_W-1:0] ev_ph,
    input  wire logic               ev_rise,
    output logic      [5:0]         cap_stb,
    output logic      [NS_W-1:0]    cap_ns,
    output logic      [SEC_W-1:0]   cap_sec,
    output logic      [PHASE_W-1:0] cap_phase,
    output logic                    cap_rise
);
    initial begin
        {cap_stb, cap_ns, cap_sec, cap_phase, cap_rise} = '0;
    end
    always @(posedge mclk) begin
        cap_stb <= ev_mask;
        if (ev_mask != 6'h00) begin
            {cap_ns, cap_sec} <= {ev_ns, ev_sec};
            {cap_phase, cap_rise} <= {ev_ph, ev_rise};
        end else begin
            // Idle values toggle so stale data cannot pass
            {cap_ns, cap_sec} <= ~{cap_ns, cap_sec};
            {cap_phase, cap_rise} <= ~{cap_phase, cap_rise};
        end
    end
endmodule

//--- event_timestamp_sample_readout_tb.sv
`timescale 1ns/1ps
// ----------------------------------------
// Capture and readout checks
// ----------------------------------------
module event_timestamp_sample_readout_tb;
    import etsr_pkg::*;
    logic                mclk;
    logic                reset_n;
    logic [31:0]         unit_index;
    logic                rd_en;
    logic [11:0]         rd_addr;
    logic [31:0]         rd_data;
    logic                rd_valid;
    logic                rd_hit;
    logic [5:0]          ev_mask;
    logic [NS_W-1:0]     ev_ns;
    logic [SEC_W-1:0]    ev_sec;
    logic [PHASE_W-1:0]  ev_ph;
    logic                ev_rise;
    logic [5:0]          cap_stb;
    logic [NS_W-1:0]     cap_ns;
    logic [SEC_W-1:0]    cap_sec;
    logic [PHASE_W-1:0]  cap_phase;
    logic                cap_rise;
    logic [NS_W-1:0]     m_ns [6];
    logic [31:0]         m_sec [6];
    logic [2:0]          m_ph [6];
    logic                m_rise [6];
    logic [32:0]         q_exp [$];
    logic [32:0]         e;
    logic [11:0]         al [8];
    logic [2:0]          codes [5];
    int                  fails;
    int                  comparisons;
    int                  n;
    int                  k;
    integer              seed;

    etsr_top etsr_top_i (.mclk(mclk), .reset_n(reset_n),
        .unit_index(unit_index), .cap_stb(cap_stb), .cap_ns(cap_ns),
        .cap_sec(cap_sec), .cap_phase(cap_phase), .cap_rise(cap_rise),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data),
        .rd_valid(rd_valid), .rd_hit(rd_hit));
    etsr_evt_src etsr_evt_src_i (.mclk(mclk), .ev_mask(ev_mask),
        .ev_ns(ev_ns), .ev_sec(ev_sec), .ev_ph(ev_ph), .ev_rise(ev_rise),
        .cap_stb(cap_stb), .cap_ns(cap_ns), .cap_sec(cap_sec),
        .cap_phase(cap_phase), .cap_rise(cap_rise));

    task automatic final_report;
        $display("Counts: %0d comparisons, %0d fails", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [32:0] s,
                       input logic [32:0] x);
        comparisons++;
        if (s !== x) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, x, s);
        end
    endtask

    function automatic logic [32:0] exp_rd(input logic [11:0] a,
                                           input int u);
        int b;
        b = u * 3;
        case (a)
            SAMPLE5_SECONDS_OFS:     exp_rd = {1'b1, m_sec[b]};
            SAMPLE5_PHASE_OFS:       exp_rd = {1'b1, 29'h0, m_ph[b]};
            SAMPLE6_NANOSECONDS_OFS: exp_rd = {2'h2, m_rise[b+1], m_ns[b+1]};
            SAMPLE6_SECONDS_OFS:     exp_rd = {1'b1, m_sec[b+1]};
            SAMPLE6_PHASE_OFS:       exp_rd = {1'b1, 29'h0, m_ph[b+1]};
            SAMPLE7_NANOSECONDS_OFS: exp_rd = {2'h2, m_rise[b+2], m_ns[b+2]};
            default:                 exp_rd = 33'h0;
        endcase
    endfunction

    task automatic clear_model;
        for (int i = 0; i < 6; i++) begin
            {m_ns[i], m_sec[i], m_ph[i], m_rise[i]} = '0;
        end
    endtask

    // Back-to-back reads of every address, two unmapped among them
    task automatic sweep(input int u);
        for (int j = 0; j < 8; j++) begin
            rd_en <= 1'b1;
            rd_addr <= al[j];
            unit_index <= ($random(seed) & 32'hFFFF_FEFF) | (u << 8);
            q_exp.push_back(exp_rd(al[j], u));
            @(posedge mclk);
        end
        rd_en <= 1'b0;
        @(posedge mclk);
    endtask

    always @(posedge mclk) begin
        if (rd_valid === 1'b1) begin
            if (q_exp.size() == 0) begin
                chk("rd_valid", {32'h0, rd_valid}, 33'h0);
            end else begin
                e = q_exp.pop_front();
                chk("rd_data", {1'b0, rd_data},
                    {1'b0, e[31:0]});
                chk("rd_hit", {32'h0, rd_hit}, {32'h0, e[32]});
            end
        end
    end

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        final_report();
    end

    initial begin
        seed = 32'h26D02680;
        {reset_n, rd_en, rd_addr, unit_index, ev_mask} = '0;
        {ev_ns, ev_sec, ev_ph, ev_rise} = '0;
        al = '{SAMPLE5_SECONDS_OFS, SAMPLE5_PHASE_OFS, 12'h584, 12'h5A0,
               SAMPLE6_NANOSECONDS_OFS, SAMPLE6_SECONDS_OFS,
               SAMPLE6_PHASE_OFS, SAMPLE7_NANOSECONDS_OFS};
        codes = '{PH_0NS, PH_8NS, PH_16NS, PH_24NS, PH_32NS};
        clear_model();
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        sweep(0);
        sweep(1);
        for (n = 0; n < 12; n++) begin
            k = n % 6;
            ev_mask <= (6'h01 << k) |
                       ((n > 5) ? 6'h01 << ((k + 3) % 6) : 6'h00);
            ev_ns <= NS_W'($random(seed));
            ev_sec <= $random(seed);
            ev_ph <= codes[n % 5];
            ev_rise <= n[0];
            @(posedge mclk);
            ev_mask <= 6'h00;
            for (int i = 0; i < 6; i++) begin
                if (ev_mask[i]) begin
                    {m_ns[i], m_sec[i], m_ph[i], m_rise[i]} =
                        {ev_ns, ev_sec, ev_ph, ev_rise};
                end
            end
            repeat (2) @(posedge mclk);
            sweep(0);
            sweep(1);
        end
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        clear_model();
        sweep(0);
        sweep(1);
        for (k = 0; k < 10 && q_exp.size() > 0; k++) begin
            @(posedge mclk);
        end
        if (q_exp.size() != 0) begin
            fails++;
        end
        final_report();
    end
endmodule
